// ### inc/eipl_pkg.sv
// Shared constants, register map and helpers for the external interrupt pin logic.
package eipl_pkg;

  // ----------------------------------------------------------------
  // Bus and pin geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NPIN   = 2;
  localparam int unsigned PIN_A  = 0;
  localparam int unsigned PIN_B  = 1;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS  = 12'h088;
  localparam logic [11:0] BITOP_OFS = 12'h08C;
  localparam logic [11:0] STAT_OFS  = 12'h090;
  localparam logic [11:0] MASK_OFS  = 12'h094;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned TYPE_A_BIT    = 0;
  localparam int unsigned FLAG_A_BIT    = 1;
  localparam int unsigned TYPE_B_BIT    = 2;
  localparam int unsigned FLAG_B_BIT    = 3;
  localparam int unsigned BITOP_VAL_BIT = 8;
  localparam int unsigned STAT_W        = 3;
  localparam int unsigned ST_WAKE_BIT   = 2;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [2:0]  STAT_RST      = 3'h0;
  localparam logic [2:0]  MASK_RST      = 3'h0;
  localparam logic        TRIG_LEVEL    = 1'b0;
  localparam logic        TRIG_FALL     = 1'b1;
  localparam logic        PIN_IDLE      = 1'b1;
  localparam logic        PREV_RST      = 1'b0;

  // Packs type and flag bits into the control register layout.
  function automatic logic [7:0] ctrl_pack(input logic [1:0] ttype, input logic [1:0] flag);
    logic [7:0] v;
    v = CTRL_RST;
    v[TYPE_A_BIT] = ttype[PIN_A];
    v[FLAG_A_BIT] = flag[PIN_A];
    v[TYPE_B_BIT] = ttype[PIN_B];
    v[FLAG_B_BIT] = flag[PIN_B];
    return v;
  endfunction

endpackage

// ### rtl/eipl_sync.sv
// Two-flop synchroniser for the external interrupt pins.
`timescale 1ns/1ps
module eipl_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             i_sys_clk, // System clock
  input  wire logic             i_rst,     // Synchronous reset, active high
  input  wire logic             i_clk_en,  // Freezes state while low
  input  wire logic [WIDTH-1:0] i_d,       // Asynchronous pin levels
  output logic      [WIDTH-1:0] o_q        // Synchronised levels
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second one.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta <= {WIDTH{eipl_pkg::PIN_IDLE}};
      o_q  <= {WIDTH{eipl_pkg::PIN_IDLE}};
    end else if (i_clk_en) begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

  AST_SYNC_LATENCY: assert property (
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_clk_en ##1 i_clk_en) |=> (o_q == $past(i_d, 2)))
    else $error("synchroniser output is not the pin two cycles back");

endmodule

// ### rtl/eipl_trig.sv
// Per-pin trigger detection and request flag.
`timescale 1ns/1ps
module eipl_trig (
  input  wire logic i_sys_clk, // System clock
  input  wire logic i_rst,     // Synchronous reset, active high
  input  wire logic i_clk_en,  // Freezes state while low
  input  wire logic i_pin,     // Synchronised pin level
  input  wire logic i_type,    // Trigger type, 1 is falling edge
  input  wire logic i_wr,      // Software write of the flag
  input  wire logic i_wr_val,  // Value written to the flag
  input  wire logic i_svc,     // Service routine entered, pulse
  output logic      o_flag,    // Request flag
  output logic      o_edge     // Falling edge seen in edge mode, pulse
);

  logic prev;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prev <= eipl_pkg::PREV_RST;
    end else if (i_clk_en) begin
      prev <= i_pin;
    end
  end

  assign o_edge = i_clk_en & (i_type == eipl_pkg::TRIG_FALL) & prev & ~i_pin;

  // A new edge beats a clear in the same cycle, so no event is lost.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_flag <= 1'b0;
    end else if (i_clk_en) begin
      if (i_type == eipl_pkg::TRIG_LEVEL) begin
        o_flag <= ~i_pin;
      end else if (o_edge) begin
        o_flag <= 1'b1;
      end else if (i_wr) begin
        o_flag <= i_wr_val;
      end else if (i_svc) begin
        o_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_EDGE_SETS_FLAG: assert property (
    (i_clk_en && i_type && prev && !i_pin) |=> o_flag)
    else $error("falling edge did not set the flag");

  AST_LEVEL_MIRROR: assert property (
    (i_clk_en && !i_type) |=> (o_flag == !$past(i_pin)))
    else $error("level mode flag is not the inverted pin");

  AST_SVC_CLEARS: assert property (
    (i_clk_en && i_type && i_svc && !i_wr && !o_edge) |=> !o_flag)
    else $error("service entry did not clear the edge flag");

  AST_EDGE_HOLD: assert property (
    (i_clk_en && i_type && o_flag && !i_svc && !i_wr) |=> o_flag)
    else $error("edge flag dropped with no clear");

  AST_LEVEL_NO_SVC_CLEAR: assert property (
    (i_clk_en && !i_type && i_svc && !i_pin) |=> o_flag)
    else $error("service entry cleared a level flag");

  AST_LEVEL_REREQUEST: assert property (
    (i_clk_en && !i_type && !i_pin) ##1 (i_clk_en && !i_type && !i_pin) |=> o_flag [*1])
    else $error("held low pin did not keep requesting");

endmodule

// ### rtl/eipl_top.sv
// External interrupt pin logic with an APB register slave.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

module eipl_top (
  input  wire logic        i_sys_clk,       // System clock, 25 MHz
  input  wire logic        i_rst,           // Synchronous reset, active high
  input  wire logic        i_clk_en,        // Freezes all state while low
  input  wire logic        i_ext_irq_pin_a, // External interrupt pin a
  input  wire logic        i_ext_irq_pin_b, // External interrupt pin b
  input  wire logic        i_svc_enter_a,   // Service routine a entered, pulse
  input  wire logic        i_svc_enter_b,   // Service routine b entered, pulse
  input  wire logic        i_power_down,    // Device is in power-down
  input  wire logic        i_psel,          // APB select
  input  wire logic        i_penable,       // APB enable
  input  wire logic        i_pwrite,        // APB write
  input  wire logic [11:0] i_paddr,         // APB byte address
  input  wire logic [31:0] i_pwdata,        // APB write data
  input  wire logic [3:0]  i_pstrb,         // APB byte strobes
  output logic      [31:0] o_prdata,        // APB read data
  output logic             o_pready,        // APB ready
  output logic             o_pslverr,       // APB error, unmapped address
  output logic             o_req_a,         // Request flag of pin a
  output logic             o_req_b,         // Request flag of pin b
  output logic             o_wake,          // Wake from power-down
  output logic             o_irq            // Unmasked status interrupt
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]  pin_raw;
  logic [1:0]  pin_sync;
  logic [1:0]  trig_type;
  logic [1:0]  flag;
  logic [1:0]  edge_evt;
  logic [1:0]  svc;
  logic [1:0]  wr_flag;
  logic [1:0]  wr_val;
  logic [1:0]  trig_now;
  logic [2:0]  stat;
  logic [2:0]  mask;
  logic [2:0]  stat_set;
  logic [2:0]  stat_clr;
  logic        access;
  logic        done;
  logic        wr_done;
  logic        ctrl_wr;
  logic        bitop_wr;
  logic        stat_wr;
  logic        mask_wr;
  logic        wake_cond;
  logic [7:0]  bit_sel;
  logic        bit_val;
  logic [31:0] next_rdata;
  logic        next_err;

  // ----------------------------------------------------------------
  // Pin synchronisation and per-pin trigger logic
  // ----------------------------------------------------------------
  assign pin_raw = {i_ext_irq_pin_b, i_ext_irq_pin_a};
  assign svc     = {i_svc_enter_b, i_svc_enter_a};

  // Pulses narrower than a clock cycle may be missed entirely.
  eipl_sync #(
    .WIDTH (eipl_pkg::NPIN)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_clk_en  (i_clk_en),
    .i_d       (pin_raw),
    .o_q       (pin_sync)
  );

  for (genvar g = 0; g < eipl_pkg::NPIN; g++) begin : g_pin
    eipl_trig u_trig (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_clk_en  (i_clk_en),
      .i_pin     (pin_sync[g]),
      .i_type    (trig_type[g]),
      .i_wr      (wr_flag[g]),
      .i_wr_val  (wr_val[g]),
      .i_svc     (svc[g]),
      .o_flag    (flag[g]),
      .o_edge    (edge_evt[g])
    );
  end

  // The flags are the request lines; an edge-mode flag latches a past edge until it is cleared.
  assign o_req_a = flag[eipl_pkg::PIN_A];
  assign o_req_b = flag[eipl_pkg::PIN_B];

  // ----------------------------------------------------------------
  // APB slave with one wait state
  // ----------------------------------------------------------------
  assign access   = i_psel & i_penable;
  assign done     = access & o_pready;
  assign wr_done  = done & i_pwrite & i_pstrb[0] & i_clk_en;
  assign ctrl_wr  = wr_done & (i_paddr == eipl_pkg::CTRL_OFS);
  assign bitop_wr = wr_done & i_pstrb[1] & (i_paddr == eipl_pkg::BITOP_OFS);
  assign stat_wr  = wr_done & (i_paddr == eipl_pkg::STAT_OFS);
  assign mask_wr  = wr_done & (i_paddr == eipl_pkg::MASK_OFS);

  // Ready comes from a flop, which costs one wait state per transfer.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else if (i_clk_en) begin
      o_pready <= access & ~o_pready;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    unique case (i_paddr)
      eipl_pkg::CTRL_OFS: begin
        next_rdata[7:0] = eipl_pkg::ctrl_pack(trig_type, flag);
      end
      eipl_pkg::BITOP_OFS: begin
        next_rdata = 32'h0000_0000;
      end
      eipl_pkg::STAT_OFS: begin
        next_rdata[2:0] = stat;
      end
      eipl_pkg::MASK_OFS: begin
        next_rdata[2:0] = mask;
      end
      default: begin
        next_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      if (access & ~o_pready) begin
        o_prdata  <= i_pwrite ? 32'h0000_0000 : next_rdata;
        o_pslverr <= next_err;
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register: trigger types and flag writes
  // ----------------------------------------------------------------
  // The bit operation register updates chosen control bits in one
  // atomic write, standing in for the core's single-bit access.
  assign bit_sel = i_pwdata[7:0];
  assign bit_val = i_pwdata[eipl_pkg::BITOP_VAL_BIT];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      trig_type <= {eipl_pkg::CTRL_RST[eipl_pkg::TYPE_B_BIT],
                    eipl_pkg::CTRL_RST[eipl_pkg::TYPE_A_BIT]};
    end else if (i_clk_en) begin
      if (ctrl_wr) begin
        trig_type[eipl_pkg::PIN_A] <= i_pwdata[eipl_pkg::TYPE_A_BIT];
        trig_type[eipl_pkg::PIN_B] <= i_pwdata[eipl_pkg::TYPE_B_BIT];
      end else if (bitop_wr) begin
        if (bit_sel[eipl_pkg::TYPE_A_BIT]) begin
          trig_type[eipl_pkg::PIN_A] <= bit_val;
        end
        if (bit_sel[eipl_pkg::TYPE_B_BIT]) begin
          trig_type[eipl_pkg::PIN_B] <= bit_val;
        end
      end
    end
  end

  // Level mode drops these writes inside the trigger logic.
  always_comb begin
    wr_flag[eipl_pkg::PIN_A] = ctrl_wr | (bitop_wr & bit_sel[eipl_pkg::FLAG_A_BIT]);
    wr_flag[eipl_pkg::PIN_B] = ctrl_wr | (bitop_wr & bit_sel[eipl_pkg::FLAG_B_BIT]);
    wr_val[eipl_pkg::PIN_A]  = ctrl_wr ? i_pwdata[eipl_pkg::FLAG_A_BIT] : bit_val;
    wr_val[eipl_pkg::PIN_B]  = ctrl_wr ? i_pwdata[eipl_pkg::FLAG_B_BIT] : bit_val;
  end

  // ----------------------------------------------------------------
  // Power-down wake
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < eipl_pkg::NPIN; i++) begin
      trig_now[i] = trig_type[i] ? edge_evt[i] : ~pin_sync[i];
    end
  end

  assign wake_cond = i_power_down & (|trig_now);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_wake <= 1'b0;
    end else if (i_clk_en) begin
      o_wake <= wake_cond;
    end
  end

  // ----------------------------------------------------------------
  // Sticky event status, mask and interrupt output
  // ----------------------------------------------------------------
  assign stat_set = {wake_cond, edge_evt};
  assign stat_clr = stat_wr ? i_pwdata[eipl_pkg::STAT_W-1:0] : eipl_pkg::STAT_RST;

  // A set in the same cycle as a write-one clear wins.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      stat <= eipl_pkg::STAT_RST;
    end else if (i_clk_en) begin
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      mask <= eipl_pkg::MASK_RST;
    end else if (i_clk_en && mask_wr) begin
      mask <= i_pwdata[eipl_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= |(stat & mask);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_CTRL_LAYOUT: assert property (
    (i_clk_en && access && !o_pready && !i_pwrite && i_paddr == eipl_pkg::CTRL_OFS)
    |=> (o_prdata[3:0] == {$past(flag[1]), $past(trig_type[1]),
                           $past(flag[0]), $past(trig_type[0])}) && (o_prdata[31:4] == 28'h0))
    else $error("control read does not show the flag and type layout");

  AST_REQ_NOT_KEPT: assert property (
    (i_clk_en && !trig_type[eipl_pkg::PIN_A] && pin_sync[eipl_pkg::PIN_A]) |=> !o_req_a)
    else $error("level request kept after the pin went high");

  AST_WAKE_ON_TRIGGER: assert property (
    (i_clk_en && i_power_down && !trig_type[0] && !pin_sync[0]) |=> o_wake)
    else $error("low level did not wake the device");

  AST_WAKE_ON_EDGE: assert property (
    (i_clk_en && i_power_down && edge_evt[1]) |=> o_wake)
    else $error("falling edge did not wake the device");

  AST_TYPE_WRITE: assert property (
    ctrl_wr |=> (trig_type == {$past(i_pwdata[2]), $past(i_pwdata[0])}))
    else $error("type bits not taken from the control write");

  AST_IRQ_FROM_EDGE: assert property (
    (i_clk_en && edge_evt[0] && mask[0] && !stat_wr) ##1 (i_clk_en && mask[0] && !stat_wr)
    |=> o_irq)
    else $error("unmasked edge event did not raise the interrupt");

  AST_APB_ONE_WAIT: assert property (
    (i_clk_en && access && !o_pready) |=> o_pready)
    else $error("slave did not answer after one wait state");

  // ----------------------------------------------------------------
  // Register, status and wake checks
  // ----------------------------------------------------------------
  // Reset is checked on its own, so the default disable is switched off here.
  AST_RESET_CLEARS_CTRL: assert property (
    @(posedge i_sys_clk) disable iff (1'b0)
    i_rst |=> (eipl_pkg::ctrl_pack(trig_type, flag) == eipl_pkg::CTRL_RST))
    else $error("control bits are not zero after reset");

  AST_BITOP_TYPE_A: assert property (
    (bitop_wr && bit_sel[eipl_pkg::TYPE_A_BIT])
    |=> (trig_type[eipl_pkg::PIN_A] == $past(bit_val)))
    else $error("single-bit write missed the type bit of pin a");

  AST_LEVEL_WRITE_IGNORED: assert property (
    (ctrl_wr && !trig_type[eipl_pkg::PIN_B])
    |=> (flag[eipl_pkg::PIN_B] == !$past(pin_sync[eipl_pkg::PIN_B])))
    else $error("software write moved a level flag");

  AST_EDGE_B_SETS_FLAG: assert property (
    (i_clk_en && trig_type[eipl_pkg::PIN_B] && edge_evt[eipl_pkg::PIN_B])
    |=> o_req_b)
    else $error("falling edge on pin b did not raise its request");

  AST_SVC_B_CLEARS: assert property (
    (i_clk_en && trig_type[eipl_pkg::PIN_B] && i_svc_enter_b
     && !wr_flag[eipl_pkg::PIN_B] && !edge_evt[eipl_pkg::PIN_B]) |=> !o_req_b)
    else $error("service entry did not clear the request of pin b");

  // A set and a write-one clear in one cycle must leave the bit set.
  AST_STAT_SET_WINS: assert property (
    edge_evt[eipl_pkg::PIN_A] |=> stat[eipl_pkg::PIN_A])
    else $error("edge event lost against a status clear");

  AST_MASK_WRITE: assert property (
    mask_wr |=> (mask == $past(i_pwdata[eipl_pkg::STAT_W-1:0])))
    else $error("mask write did not land");

  // The interrupt line must never run ahead of an unmasked status bit.
  AST_IRQ_ONLY_UNMASKED: assert property (
    (i_clk_en && !(|(stat & mask)))
    |=> !o_irq)
    else $error("interrupt raised with no unmasked status bit");

  AST_WAKE_NEEDS_PDOWN: assert property (
    (i_clk_en && !i_power_down) |=> !o_wake)
    else $error("wake raised outside power-down");

  // A frozen clock enable must hold the flags as well as the registers.
  AST_FREEZE: assert property (
    !i_clk_en |=> ($stable(trig_type) && $stable(flag) && $stable(stat) && $stable(mask)))
    else $error("state changed while the clock enable was low");

  COV_EDGE_A: cover property (edge_evt[0] ##1 o_req_a);
  COV_SVC_CLEAR: cover property (trig_type[0] && o_req_a && i_svc_enter_a ##1 !o_req_a);
  COV_LEVEL_WAKE: cover property (i_power_down && !trig_type[1] && !pin_sync[1] ##1 o_wake);
  COV_IRQ: cover property (!o_irq ##1 o_irq);
  COV_FREEZE: cover property (!i_clk_en ##1 i_clk_en ##3 o_req_b);

endmodule

// ### sim/eipl_pin_drv.sv
// Behavioural model of the external devices that drive the two interrupt pins.
`timescale 1ns/1ps
module eipl_pin_drv (
  input  wire logic       i_sys_clk, // System clock
  input  wire logic       i_rst,     // Synchronous reset, active high
  input  wire logic [1:0] i_req,     // Device wants service, level
  input  wire logic [1:0] i_svc,     // Service routine entered, pulse
  output logic      [1:0] o_pin      // Pin levels, low requests
);
  logic [1:0] served;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Levels change only on clock edges, so every level lasts a whole cycle.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_pin  <= 2'h3;
      served <= 2'h0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (i_req[k]) begin
          o_pin[k] <= 1'b0;
          if (i_svc[k]) served[k] <= 1'b1;
        end else if (served[k] || i_svc[k]) begin
          // The pin is let go only once its request has been serviced.
          o_pin[k]  <= 1'b1;
          served[k] <= 1'b0;
        end
      end
    end
  end
endmodule

// ### sim/eipl_tb_top.sv
// Self-checking testbench of the external interrupt pin logic.
`timescale 1ns/1ps
module eipl_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, svc_a, svc_b, pdown;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        pready, pslverr, req_a, req_b, wake, irq, wake_seen, clk_en;
  logic [1:0]  dev_req, pins;
  logic [32:0] exp_q[$];
  logic [32:0] note;
  logic [31:0] seed = 32'h0000_bebe;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;

  always #20 clk = ~clk;

  eipl_pin_drv u_dev (.i_sys_clk(clk), .i_rst(rst), .i_req(dev_req),
                      .i_svc({svc_b, svc_a}), .o_pin(pins));

  eipl_top dut (
    .i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en),
    .i_ext_irq_pin_a(pins[0]), .i_ext_irq_pin_b(pins[1]),
    .i_svc_enter_a(svc_a), .i_svc_enter_b(svc_b), .i_power_down(pdown),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_req_a(req_a), .o_req_b(req_b), .o_wake(wake),
    .o_irq(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // The request is held until pready is sampled high, then one idle cycle follows.
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    exp_q.push_back({err, exp});
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pulse_svc(input logic a, input logic b);
    svc_a <= a;
    svc_b <= b;
    @(posedge clk);
    svc_a <= 1'b0;
    svc_b <= 1'b0;
    wait_cyc(2);
  endtask

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (rst) wake_seen = 1'b0;
    else if (wake === 1'b1) wake_seen = 1'b1;
    if (psel && penable && !pwrite && pready === 1'b1) begin
      note = exp_q.pop_front();
      check("prdata", prdata, note[31:0]);
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
    end
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, svc_a, svc_b, pdown} = 6'h00;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hf;
    clk_en  = 1'b1;
    dev_req = 2'h0;
    wait_cyc(8);
    rst <= 1'b0;
    @(posedge clk);
    check("req after reset", {29'h0, req_b, req_a, irq}, 32'h0000_0000);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_0000, 1'b0);
    rd(eipl_pkg::STAT_OFS, 32'h0000_0000, 1'b0);
    rd(eipl_pkg::MASK_OFS, 32'h0000_0000, 1'b0);
    rd(12'h0a0, 32'h0000_0000, 1'b1);
    xfer(1'b1, eipl_pkg::MASK_OFS, 32'h0000_0001);
    rd(eipl_pkg::MASK_OFS, 32'h0000_0001, 1'b0);
    // Level mode on both pins, the default after reset.
    dev_req <= 2'h3;
    wait_cyc(6);
    check("level flags", {30'h0, req_b, req_a}, 32'h0000_0003);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_000a, 1'b0);
    xfer(1'b1, eipl_pkg::CTRL_OFS, 32'h0000_0000);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_000a, 1'b0);
    pulse_svc(1'b1, 1'b1);
    check("level after svc", {30'h0, req_b, req_a}, 32'h0000_0003);
    dev_req <= 2'h0;
    wait_cyc(6);
    check("level released", {30'h0, req_b, req_a}, 32'h0000_0000);
    // Edge mode; random upper bits must not land anywhere.
    xfer(1'b1, eipl_pkg::STAT_OFS, 32'h0000_0007);
    seed = lfsr_next(seed);
    xfer(1'b1, eipl_pkg::CTRL_OFS, {seed[31:4], 4'h5});
    rd(eipl_pkg::CTRL_OFS, 32'h0000_0005, 1'b0);
    dev_req <= 2'h1;
    wait_cyc(6);
    check("edge flag a", {31'h0, req_a}, 32'h0000_0001);
    dev_req <= 2'h0;
    wait_cyc(3);
    check("edge flag kept", {31'h0, req_a}, 32'h0000_0001);
    rd(eipl_pkg::STAT_OFS, 32'h0000_0001, 1'b0);
    check("irq masked in", {31'h0, irq}, 32'h0000_0001);
    xfer(1'b1, eipl_pkg::STAT_OFS, 32'h0000_0001);
    wait_cyc(2);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    xfer(1'b1, eipl_pkg::BITOP_OFS, 32'h0000_0002);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_0005, 1'b0);
    xfer(1'b1, eipl_pkg::BITOP_OFS, 32'h0000_0102);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_0007, 1'b0);
    pulse_svc(1'b1, 1'b0);
    check("svc clears edge", {31'h0, req_a}, 32'h0000_0000);
    wait_cyc(6);
    check("rise sets nothing", {31'h0, req_a}, 32'h0000_0000);
    // Wake from power-down by pin b.
    check("no wake yet", {31'h0, wake_seen}, 32'h0000_0000);
    pdown   <= 1'b1;
    dev_req <= 2'h2;
    wait_cyc(6);
    check("edge flag b", {31'h0, req_b}, 32'h0000_0001);
    check("wake seen", {31'h0, wake_seen}, 32'h0000_0001);
    rd(eipl_pkg::STAT_OFS, 32'h0000_0006, 1'b0);
    check("irq b masked", {31'h0, irq}, 32'h0000_0000);
    dev_req <= 2'h0;
    pdown   <= 1'b0;
    pulse_svc(1'b0, 1'b1);
    check("svc clears b", {31'h0, req_b}, 32'h0000_0000);
    wait_cyc(4);
    // Clock enable low: a falling edge on pin b waits until it is raised again.
    clk_en  <= 1'b0;
    dev_req <= 2'h2;
    wait_cyc(6);
    check("frozen flag b", {31'h0, req_b}, 32'h0000_0000);
    clk_en <= 1'b1;
    wait_cyc(6);
    check("thawed flag b", {31'h0, req_b}, 32'h0000_0001);
    // Mid-run reset, then a level wake on both pins.
    rst     <= 1'b1;
    dev_req <= 2'h0;
    wait_cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    check("req after reset 2", {29'h0, req_b, req_a, irq}, 32'h0000_0000);
    rd(eipl_pkg::CTRL_OFS, 32'h0000_0000, 1'b0);
    pdown   <= 1'b1;
    dev_req <= 2'h3;
    wait_cyc(6);
    check("level wake", {31'h0, wake_seen}, 32'h0000_0001);
    check("level wake flags", {30'h0, req_b, req_a}, 32'h0000_0003);
    pdown <= 1'b0;
    wait_cyc(2);
    tally_and_finish();
  end
endmodule
